/* File: rtl/act_counter.sv */
// Shared 16-bit array counter with snapshot reads and overflow flag
`timescale 1ns/1ns
`default_nettype none
module act_counter (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Mode controls
  input  wire act_pkg::act_tb_t timebase_select_i,
  input  wire logic             idle_stop_control_i,
  input  wire logic             cpu_idle_i,
  input  wire logic             overflow_irq_enable_i,
  input  wire logic             global_irq_enable_i,
  input  wire logic             array_irq_enable_i,
  input  wire logic             wdt_disable_i,
  // Count sources
  input  wire logic             t0_ovf_i,
  input  wire logic             external_count_input_i,
  input  wire logic             ext_osc_i,
  // Software access
  input  wire logic             rd_low_i,
  input  wire logic             rd_high_i,
  input  wire logic             flag_clr_i,
  output var  logic [7:0]       rd_data_o,
  // Status
  output var  logic [15:0]      count_o,
  output var  logic             counter_overflow_flag_o,
  output var  logic             irq_o,
  output var  logic             wdt_active_o
);
  import act_pkg::*;

  act_tick_if tick_bus ();

  logic [15:0] cnt_r,  cnt_nxt;
  logic [7:0]  snap_r, snap_nxt;
  logic [7:0]  rdat_r, rdat_nxt;
  logic        flag_r, flag_nxt;
  logic        irq_r,  irq_nxt;
  logic        wdt_r,  wdt_nxt;
  logic        run;
  logic        wrap;
  // Check helpers only: cycles since the timebase selection last changed
  act_tb_t     sel_prev_r, sel_prev_nxt;
  logic [3:0]  sel_age_r,  sel_age_nxt;

  act_timebase act_timebase_i (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .sel_i     (timebase_select_i),
    .t0_ovf_i  (t0_ovf_i),
    .ext_cnt_i (external_count_input_i),
    .ext_osc_i (ext_osc_i),
    .tick_o    (tick_bus.src)
  );

  ////////////////////////////////////////////////////////////////////////
  // Counter, snapshot and flag
  always_comb begin
    run      = tick_bus.tick & ~(idle_stop_control_i & cpu_idle_i);
    wrap     = run & (cnt_r == CNT_MAX);
    cnt_nxt  = run ? cnt_r + 16'h0001 : cnt_r;
    // Snapshot taken on the low read so a later high read is coherent
    snap_nxt = rd_low_i ? cnt_r[15:8] : snap_r;
    if (rd_low_i) begin
      rdat_nxt = cnt_r[7:0];
    end else if (rd_high_i) begin
      rdat_nxt = snap_r;
    end else begin
      rdat_nxt = rdat_r;
    end
    // Set wins over a same-cycle clear so no wrap is lost
    flag_nxt = wrap | (flag_r & ~flag_clr_i);
    irq_nxt  = flag_nxt & overflow_irq_enable_i
             & global_irq_enable_i & array_irq_enable_i;
    // Watchdog mode holds until software turns it off
    wdt_nxt  = wdt_r & ~wdt_disable_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r  <= CNT_RST;
      snap_r <= BYTE_RST;
      rdat_r <= BYTE_RST;
      flag_r <= 1'b0;
      irq_r  <= 1'b0;
      wdt_r  <= 1'b1;
    end else begin
      cnt_r  <= cnt_nxt;
      snap_r <= snap_nxt;
      rdat_r <= rdat_nxt;
      flag_r <= flag_nxt;
      irq_r  <= irq_nxt;
      wdt_r  <= wdt_nxt;
    end
  end

  assign count_o                 = cnt_r;
  assign rd_data_o               = rdat_r;
  assign counter_overflow_flag_o = flag_r;
  assign irq_o                   = irq_r;
  assign wdt_active_o            = wdt_r;

  ////////////////////////////////////////////////////////////////////////
  // Selection age, saturating so it never wraps back into a check window
  // Feeds the divide by 12 rate check only; it changes nothing the block drives
  always_comb begin
    sel_prev_nxt = timebase_select_i;
    if (timebase_select_i != sel_prev_r) begin
      sel_age_nxt = PRE_RST;
    end else if (&sel_age_r) begin
      sel_age_nxt = sel_age_r;
    end else begin
      sel_age_nxt = sel_age_r + PRE_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sel_prev_r <= ACT_TB_DIV12;
      sel_age_r  <= PRE_RST;
    end else begin
      sel_prev_r <= sel_prev_nxt;
      sel_age_r  <= sel_age_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_wrap_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cnt_r == CNT_MAX && cnt_nxt == CNT_RST) |=> counter_overflow_flag_o)
    else $error("wrap did not set overflow flag");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (flag_r && !flag_clr_i) |=> flag_r)
    else $error("overflow flag dropped without clear");
  a_high_snapshot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_low_i ##1 (rd_high_i && !rd_low_i)) |=> (rd_data_o == $past(cnt_r[15:8], 2)))
    else $error("high read did not return snapshot");
  a_low_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_low_i |=> (rd_data_o == $past(cnt_r[7:0])))
    else $error("low read wrong");
  a_sys_counts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (timebase_select_i == ACT_TB_SYS && !(idle_stop_control_i && cpu_idle_i))
      |=> (cnt_r == $past(cnt_r) + 16'h0001))
    else $error("system clock timebase did not count");
  a_rsv_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (timebase_select_i == ACT_TB_RSV6 || timebase_select_i == ACT_TB_RSV7) |=> $stable(cnt_r))
    else $error("undefined timebase counted");
  a_idle_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (idle_stop_control_i && cpu_idle_i) |=> $stable(cnt_r))
    else $error("counter moved in idle with stop set");
  a_irq_gating: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_o |-> (counter_overflow_flag_o && $past(overflow_irq_enable_i)
               && $past(global_irq_enable_i) && $past(array_irq_enable_i)))
    else $error("interrupt without all enables");
  a_div4_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (timebase_select_i == ACT_TB_DIV4 && tick_bus.tick)
      |=> (!tick_bus.tick || timebase_select_i != ACT_TB_DIV4) [*3])
    else $error("divide by 4 ticked too fast");
  a_eci_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (timebase_select_i == ACT_TB_EXTIN && $fell(external_count_input_i)
      && !(idle_stop_control_i && cpu_idle_i)) |=> (cnt_r == $past(cnt_r) + 16'h0001))
    else $error("falling pin edge not counted");

  // Timebase rates and sources
  a_div12_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (timebase_select_i == ACT_TB_DIV12 && tick_bus.tick)
      |-> ##12 (tick_bus.tick || timebase_select_i != ACT_TB_DIV12 || sel_age_r <= DIV12_LAST))
    else $error("divide by 12 tick missing");
  a_div12_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (timebase_select_i == ACT_TB_DIV12 && tick_bus.tick) |=> (!tick_bus.tick || timebase_select_i != ACT_TB_DIV12) [*8])
    else $error("divide by 12 ticked too fast");
  a_t0_counts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (timebase_select_i == ACT_TB_T0OV && !(idle_stop_control_i && cpu_idle_i))
      |=> (cnt_r == $past(cnt_r) + 16'($past(t0_ovf_i))))
    else $error("timer 0 overflow count wrong");
  a_osc_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (timebase_select_i == ACT_TB_OSC8 && tick_bus.tick) |=> (!tick_bus.tick || timebase_select_i != ACT_TB_OSC8))
    else $error("oscillator tick longer than one cycle");

  // Watchdog state, flag and interrupt
  a_wdt_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wdt_active_o && !wdt_disable_i) |=> wdt_active_o)
    else $error("watchdog mode left without disable");
  a_wdt_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wdt_disable_i || !wdt_active_o) |=> !wdt_active_o)
    else $error("watchdog mode not left or entered again");
  a_irq_raise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (counter_overflow_flag_o && !flag_clr_i && overflow_irq_enable_i
      && global_irq_enable_i && array_irq_enable_i) |=> irq_o)
    else $error("interrupt missing with flag and enables set");
  a_flag_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (flag_clr_i && !wrap) |=> !counter_overflow_flag_o)
    else $error("overflow flag not cleared");
  a_flag_only_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!counter_overflow_flag_o && !wrap) |=> !counter_overflow_flag_o)
    else $error("overflow flag set without wrap");

  // Read data
  a_rdata_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!rd_low_i && !rd_high_i) |=> $stable(rd_data_o))
    else $error("read data changed without a read");
endmodule
`default_nettype wire

/* File: rtl/act_pkg.sv */
// Package of constants and types for the array counter timebase
package act_pkg;
  localparam int          CNT_W        = 16;
  localparam int          BYTE_W       = 8;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [3:0]  DIV12_LAST   = 4'hB;
  localparam logic [3:0]  DIV4_LAST    = 4'h3;
  localparam logic [3:0]  PRE_RST      = 4'h0;
  localparam logic [3:0]  PRE_ONE      = 4'h1;
  localparam logic [2:0]  EXT_DIV_LAST = 3'h7;
  localparam logic [2:0]  EXT_DIV_RST  = 3'h0;
  localparam logic [2:0]  EXT_DIV_ONE  = 3'h1;
  typedef enum logic [2:0] {
    ACT_TB_DIV12 = 3'b000,
    ACT_TB_DIV4  = 3'b001,
    ACT_TB_T0OV  = 3'b010,
    ACT_TB_EXTIN = 3'b011,
    ACT_TB_SYS   = 3'b100,
    ACT_TB_OSC8  = 3'b101,
    ACT_TB_RSV6  = 3'b110,
    ACT_TB_RSV7  = 3'b111
  } act_tb_t;
endpackage

/* File: rtl/act_tick_if.sv */
// Interface carrying the timebase tick between the selector and the counter
`timescale 1ns/1ns
`default_nettype none
interface act_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface
`default_nettype wire

/* File: rtl/act_timebase.sv */
// Timebase selector: prescalers, edge detect and oscillator sync
`timescale 1ns/1ns
`default_nettype none
module act_timebase (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // Sources
  input  wire act_pkg::act_tb_t sel_i,
  input  wire logic            t0_ovf_i,
  input  wire logic            ext_cnt_i,
  input  wire logic            ext_osc_i,
  // Tick out
  act_tick_if.src              tick_o
);
  import act_pkg::*;

  logic [3:0] pre_r,  pre_nxt;
  logic       eci_r,  eci_nxt;
  logic [2:0] osc_div_r;
  logic [2:0] osc_div_nxt;
  logic       osc_s1_r, osc_s2_r, osc_s3_r;
  logic       osc_edge;
  logic [3:0] pre_last;
  logic       tick_c;

  ////////////////////////////////////////////////////////////////////////
  // Oscillator divide by 8, runs on its own source but sampled here
  // Limitation: the divided clock must stay below half of the system clock
  always_comb begin
    osc_div_nxt = osc_div_r + EXT_DIV_ONE;
  end

  // Reset seen in the oscillator domain so the divider never starts unknown;
  // its release phase against the oscillator does not matter
  always_ff @(posedge ext_osc_i) begin
    if (!rst_n_i) begin
      osc_div_r <= EXT_DIV_RST;
    end else begin
      osc_div_r <= osc_div_nxt;
    end
  end

  // Two-flop synchroniser, third flop only for edge detect
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_div_r[2];
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end
  assign osc_edge = osc_s2_r & ~osc_s3_r;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and pin edge detector
  always_comb begin
    pre_last = (sel_i == ACT_TB_DIV4) ? DIV4_LAST : DIV12_LAST;
    pre_nxt  = (pre_r >= pre_last) ? PRE_RST : pre_r + PRE_ONE;
    eci_nxt  = ext_cnt_i;
    case (sel_i)
      ACT_TB_DIV12: tick_c = (pre_r == DIV12_LAST);
      ACT_TB_DIV4:  tick_c = (pre_r >= DIV4_LAST);
      ACT_TB_T0OV:  tick_c = t0_ovf_i;
      ACT_TB_EXTIN: tick_c = eci_r & ~ext_cnt_i;
      ACT_TB_SYS:   tick_c = 1'b1;
      ACT_TB_OSC8:  tick_c = osc_edge;
      default:      tick_c = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_r <= PRE_RST;
      eci_r <= 1'b1;
    end else begin
      pre_r <= pre_nxt;
      eci_r <= eci_nxt;
    end
  end

  assign tick_o.tick = tick_c;
endmodule
`default_nettype wire

/* File: verif/act_src_model.sv */
// Partner model: Timer 0 overflow pulses, count pin and external oscillator
`timescale 1ns/1ns
`default_nettype none
module act_src_model (
  // Clock
  input  wire logic clk_i,
  // Sources
  output wire logic t0_ovf_o,
  output wire logic ext_cnt_o,
  output var  logic ext_osc_o
);
  logic [2:0] t0_cnt_r  = 3'h0;
  logic [1:0] pin_cnt_r = 2'h0;
  initial ext_osc_o = 1'b0;
  // Free-running oscillator, unrelated in phase to the system clock
  always #30 ext_osc_o = ~ext_osc_o;
  always @(posedge clk_i) begin
    t0_cnt_r  <= (t0_cnt_r == 3'h5) ? 3'h0 : t0_cnt_r + 3'h1;
    pin_cnt_r <= pin_cnt_r + 2'h1;
  end
  assign t0_ovf_o  = (t0_cnt_r == 3'h5);
  // Two clocks high, two low: the fastest legal pin rate
  assign ext_cnt_o = pin_cnt_r[1];
endmodule
`default_nettype wire

/* File: verif/array_counter_timebase_test.sv */
// Self-checking testbench of the array counter timebase
`timescale 1ns/1ns
`default_nettype none
`define ACT_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
module array_counter_timebase_test;
  import act_pkg::*;
  typedef struct {logic [15:0] lo; logic [15:0] hi;} act_note_t;
  logic clk, t0, ecnt, osc, flag, irq, wdt_act, lo_d, hi_d;
  logic [7:0] rd_data, lo_b;
  logic [15:0] count, base, d;
  logic rst_n = 1'b0, idle_stop = 1'b0, cpu_idle = 1'b0, ovf_en = 1'b0, glb_en = 1'b0;
  logic arr_en = 1'b0, wdt_dis = 1'b0, rd_low = 1'b0, rd_high = 1'b0, flag_clr = 1'b0, base_v = 1'b0;
  act_tb_t sel = ACT_TB_DIV12;
  act_note_t notes[$];
  act_note_t nt;
  int miscompares = 0, num_checks = 0, cycles = 0;
  act_src_model act_src_model_i (.clk_i(clk), .t0_ovf_o(t0), .ext_cnt_o(ecnt), .ext_osc_o(osc));
  act_counter act_counter_i (.clk_i(clk), .rst_n_i(rst_n), .timebase_select_i(sel),
    .idle_stop_control_i(idle_stop), .cpu_idle_i(cpu_idle), .overflow_irq_enable_i(ovf_en),
    .global_irq_enable_i(glb_en), .array_irq_enable_i(arr_en), .wdt_disable_i(wdt_dis),
    .t0_ovf_i(t0), .external_count_input_i(ecnt), .ext_osc_i(osc), .rd_low_i(rd_low),
    .rd_high_i(rd_high), .flag_clr_i(flag_clr), .rd_data_o(rd_data), .count_o(count),
    .counter_overflow_flag_o(flag), .irq_o(irq), .wdt_active_o(wdt_act));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic print_verdict();
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      print_verdict();
    end
  end
  // Monitor: pairs low and high reads, checks count advance between pairs
  always @(posedge clk) begin
    lo_d <= rd_low;
    hi_d <= rd_high;
    if (lo_d === 1'b1) lo_b = rd_data;
    if (hi_d === 1'b1) begin
      if (base_v) begin
        nt = notes.pop_front();
        d = {rd_data, lo_b} - base;
        `ACT_CHK((d >= nt.lo) && (d <= nt.hi), 1'b1)
        base_v = 1'b0;
      end else begin
        base = {rd_data, lo_b};
        base_v = 1'b1;
      end
    end
  end
  // Low byte first keeps the pair coherent
  task automatic rd_pair();
    rd_low <= 1'b1;
    @(posedge clk);
    rd_low <= 1'b0;
    rd_high <= 1'b1;
    @(posedge clk);
    rd_high <= 1'b0;
  endtask
  task automatic measure(input int n, input int lo, input int hi);
    act_note_t x;
    repeat (4) @(posedge clk);
    rd_pair();
    repeat (n - 2) @(posedge clk);
    x.lo = 16'(lo);
    x.hi = 16'(hi);
    notes.push_back(x);
    rd_pair();
    @(posedge clk);
  endtask
  initial begin
    int n;
    int i;
    void'($urandom(32'h8bb2e2fd));
    repeat (11) @(posedge clk);
    #1 `ACT_CHK({count, flag, irq, wdt_act}, {CNT_RST, 3'b001})
    @(posedge clk);
    rst_n <= 1'b1;
    wdt_dis <= 1'b1;
    @(posedge clk);
    wdt_dis <= 1'b0;
    @(posedge clk);
    #1 `ACT_CHK(wdt_act, 1'b0)
    @(posedge clk);
    for (int m = 0; m < 8; m++) begin
      n = 12 * (2 + $urandom_range(8));
      sel <= act_tb_t'(m);
      cpu_idle <= 1'($urandom_range(1));
      case (m)
        0: measure(n, n / 12, n / 12);
        1: measure(n, n / 4, n / 4);
        2: measure(n, n / 6, n / 6);
        3: measure(n, n / 4, n / 4);
        4: measure(n, n, n);
        5: measure(120, 24, 26);
        default: measure(n, 0, 0);
      endcase
    end
    sel <= ACT_TB_SYS;
    idle_stop <= 1'b1;
    cpu_idle <= 1'b1;
    measure(n, 0, 0);
    cpu_idle <= 1'b0;
    measure(n, n, n);
    {ovf_en, glb_en, arr_en} <= 3'b111;
    i = 0;
    while (flag !== 1'b1 && i < 66000) begin
      @(posedge clk);
      #1 i++;
    end
    `ACT_CHK({count, irq}, {CNT_RST, 1'b1})
    for (int e = 0; e < 8; e++) begin
      @(posedge clk);
      {ovf_en, glb_en, arr_en} <= 3'(e);
      repeat (2) @(posedge clk);
      #1 `ACT_CHK({irq, flag}, {e == 7, 1'b1})
    end
    @(posedge clk);
    flag_clr <= 1'b1;
    @(posedge clk);
    flag_clr <= 1'b0;
    @(posedge clk);
    #1 `ACT_CHK({flag, irq}, 2'b00)
    print_verdict();
  end
endmodule
`default_nettype wire
